// >>> design/dtc_counter.sv
// Down counter with reload used by both timers.
`timescale 1ns/1ps
`default_nettype none
module dtc_counter
   import dtc_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] reload,
   output logic [W-1:0] count,
   output logic terminal
);
   logic [W-1:0] cnt_ff;
   logic term_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
         term_ff <= 1'b0;
      end else begin
         term_ff <= 1'b0;
         if (load) begin
            cnt_ff <= reload;
         end else if (run && tick) begin
            if (cnt_ff == '0) begin
               cnt_ff <= reload;
               term_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 1'b1;
            end
         end
      end
   end

   assign count = cnt_ff;
   assign terminal = term_ff;
endmodule
`default_nettype wire

// >>> design/dtc_edge_filter.sv
// Input pin synchroniser, glitch filter and edge detector.
`timescale 1ns/1ps
`default_nettype none
module dtc_edge_filter
   import dtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_a,
   input wire logic pin_b,
   input wire logic pin_sel,
   input wire logic [1:0] glitch_sel,
   input wire logic [1:0] edge_sel,
   output dtc_edge_t edge_o
);
   logic [1:0] meta_ff;
   logic [1:0] sync_ff;
   logic filt_ff;
   logic [3:0] cnt_ff;
   dtc_edge_t edge_ff;
   logic sel_in;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= 2'h0;
         sync_ff <= 2'h0;
      end else begin
         meta_ff <= {pin_b, pin_a};
         sync_ff <= meta_ff;
      end
   end

   assign sel_in = pin_sel ? sync_ff[1] : sync_ff[0];

   // A level change is accepted only after it holds for the full width.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_ff <= 1'b0;
         cnt_ff <= 4'h0;
      end else if (sel_in == filt_ff) begin
         cnt_ff <= 4'h0;
      end else if (cnt_ff + 4'h1 >= dtc_glitch_len(glitch_sel)) begin
         filt_ff <= sel_in;
         cnt_ff <= 4'h0;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_ff <= '0;
      end else begin
         edge_ff.rise <= edge_sel[0] && sel_in != filt_ff && sel_in &&
                         cnt_ff + 4'h1 >= dtc_glitch_len(glitch_sel);
         edge_ff.fall <= edge_sel[1] && sel_in != filt_ff && !sel_in &&
                         cnt_ff + 4'h1 >= dtc_glitch_len(glitch_sel);
      end
   end

   assign edge_o = edge_ff;
endmodule
`default_nettype wire

// >>> design/dtc_top.sv
// Control registers, counting, edge capture and pin steering of two timers.
//
// Notes on behaviour
// - Wide control bit 7 starts or stops the counter, reads enable, clears.
// - Transmit: reload-select 0 reloads at terminal count, 1 stops there.
// - Demodulation: bit 6 at 0 honours detected edges, at 1 ignores them.
// - Timeout bit 5 sets at terminal count; write 1 clears, write 0 nothing.
// - Bit 2 gates capture interrupt, bit 1 gates timeout interrupt.
// - Prescale bits 4:3 divide by 1,2,4,8; survive stop recovery with mask.
// - Wide control bit 0 routes wide output to its pin, else port data.
// - Edge detector pulses rising or falling line per edge choice bits.
// - Input pulses shorter than the programmed glitch width are discarded.
// - Disabled narrow timer outputs the inverse of its initial level bit.
// - Ping-pong: hardware alternates the two enables at terminal count.
// - Narrow control bit 0 routes narrow output to its pin.
// - Shared bit 6 puts a combination of both outputs on a third pin in transmit mode only.
// - Transmit combination field selects AND, OR, NOR or NAND.
// - Normal submode ends ping-pong; 10 forces wide output low, 11 high.
// - Wide output starts at its initial level, holds opposite when idle.
`timescale 1ns/1ps
`default_nettype none
module dtc_top
   import dtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_recovery,
   input wire logic capture_input_pin_a,
   input wire logic capture_input_pin_b,
   input wire logic port_narrow_data,
   input wire logic port_wide_data,
   input wire logic port_combined_data,
   output logic narrow_output_pin,
   output logic wide_output_pin,
   output logic combined_output_pin,
   output logic wide_capture_irq,
   output logic wide_timeout_irq
);
   logic prdy_ff;
   logic perr_ff;
   logic [31:0] prdata_ff;
   logic n_en_ff, n_single_ff, n_tout_ff, n_pin_ff;
   logic w_en_ff, w_single_ff, w_tout_ff, w_capm_ff, w_toutm_ff, w_pin_ff;
   logic [1:0] w_pre_ff;
   logic in_sel_ff;
   logic n_en_q_ff, w_en_q_ff;
   logic [7:0] n_reload_ff;
   logic [15:0] w_reload_ff;
   logic [15:0] w_capt_ff;
   logic [2:0] pre_cnt_ff;
   logic narrow_out_ff, wide_out_ff;
   logic n_pin_out_ff, w_pin_out_ff, c_pin_out_ff;
   logic w_capt_irq_ff, w_tout_irq_ff;
   dtc_mode_t mode_ff;
   dtc_mode_t nxt_mode;
   dtc_edge_t edge_s;
   logic wr, wr_nctl, wr_mode, wr_wctl;
   logic n_start, w_start, n_term, w_term, w_tick;
   logic pingpong, edge_ok, combo;
   logic [15:0] w_count;
   logic [2:0] pre_mask;

   // Writes commit at the access edge, the only edge at which the slave drives pready.
   assign wr = psel && penable && pwrite && prdy_ff;
   assign wr_nctl = wr && dtc_hit(paddr, IDX_NARROW_CTL);
   assign wr_mode = wr && dtc_hit(paddr, IDX_SHARED_MODE);
   assign wr_wctl = wr && dtc_hit(paddr, IDX_WIDE_CTL);
   assign n_start = n_en_ff && !n_en_q_ff;
   assign w_start = w_en_ff && !w_en_q_ff;
   assign pingpong = !mode_ff.demod && mode_ff.submode == SUB_PINGPONG;
   assign edge_ok = mode_ff.demod && !w_single_ff && w_en_ff &&
                    (edge_s.rise || edge_s.fall);

   // APB slave: no wait state; read data comes from a flop loaded in the setup phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdy_ff <= 1'b0;
         perr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         prdy_ff <= psel && !penable;
         perr_ff <= 1'b0;
         if (psel && !penable) begin
            prdata_ff <= 32'h0000_0000;
            if (dtc_hit(paddr, IDX_NARROW_CTL)) begin
               prdata_ff[7:0] <= {n_en_ff, n_single_ff, n_tout_ff, 4'h0,
                                  n_pin_ff};
            end else if (dtc_hit(paddr, IDX_SHARED_MODE)) begin
               prdata_ff[7:0] <= mode_ff;
            end else if (dtc_hit(paddr, IDX_WIDE_CTL)) begin
               prdata_ff[7:0] <= {w_en_ff, w_single_ff, w_tout_ff, w_pre_ff,
                                  w_capm_ff, w_toutm_ff, w_pin_ff};
            end else if (dtc_hit(paddr, IDX_SHARED_UPPER)) begin
               prdata_ff[7:0] <= {in_sel_ff, 2'h0, UPPER_RSVD};
            end else if (dtc_hit(paddr, IDX_NARROW_RELOAD)) begin
               prdata_ff[7:0] <= n_reload_ff;
            end else if (dtc_hit(paddr, IDX_WIDE_RELOAD_LO)) begin
               prdata_ff[7:0] <= w_reload_ff[7:0];
            end else if (dtc_hit(paddr, IDX_WIDE_RELOAD_HI)) begin
               prdata_ff[7:0] <= w_reload_ff[15:8];
            end else if (dtc_hit(paddr, IDX_WIDE_CAPT_LO)) begin
               prdata_ff[7:0] <= w_capt_ff[7:0];
            end else if (dtc_hit(paddr, IDX_WIDE_CAPT_HI)) begin
               prdata_ff[7:0] <= w_capt_ff[15:8];
            end else begin
               perr_ff <= 1'b1;
            end
         end
      end
   end

   // Enables: hardware hand-over first, a software write in the same cycle
   // overrides it so that an explicit stop is never undone.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_en_ff <= 1'b0;
         w_en_ff <= 1'b0;
      end else if (stop_recovery) begin
         n_en_ff <= 1'b0;
         w_en_ff <= 1'b0;
      end else begin
         if (pingpong && n_term && n_en_ff) begin
            n_en_ff <= 1'b0;
            w_en_ff <= 1'b1;
         end else if (pingpong && w_term && w_en_ff) begin
            w_en_ff <= 1'b0;
            n_en_ff <= 1'b1;
         end else begin
            if (n_term && n_single_ff) begin
               n_en_ff <= 1'b0;
            end
            if (!mode_ff.demod && w_term && w_single_ff) begin
               w_en_ff <= 1'b0;
            end
         end
         if (wr_nctl) begin
            n_en_ff <= pwdata[BIT_EN];
         end
         if (wr_wctl) begin
            w_en_ff <= pwdata[BIT_EN];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_en_q_ff <= 1'b0;
         w_en_q_ff <= 1'b0;
      end else begin
         n_en_q_ff <= n_en_ff;
         w_en_q_ff <= w_en_ff;
      end
   end

   // Plain control fields. Prescale and capture mask keep their value
   // through stop recovery; everything else returns to reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_single_ff <= 1'b0;
         n_pin_ff <= 1'b0;
         w_single_ff <= 1'b0;
         w_toutm_ff <= 1'b0;
         w_pin_ff <= 1'b0;
         in_sel_ff <= 1'b0;
         w_pre_ff <= PRE_RST;
         w_capm_ff <= 1'b0;
      end else begin
         if (stop_recovery) begin
            n_single_ff <= 1'b0;
            n_pin_ff <= 1'b0;
            w_single_ff <= 1'b0;
            w_toutm_ff <= 1'b0;
            w_pin_ff <= 1'b0;
            in_sel_ff <= 1'b0;
         end else begin
            if (wr_nctl) begin
               n_single_ff <= pwdata[BIT_SINGLE];
               n_pin_ff <= pwdata[BIT_PIN];
            end
            if (wr_wctl) begin
               w_single_ff <= pwdata[BIT_SINGLE];
               w_toutm_ff <= pwdata[BIT_TOUT_MASK];
               w_pin_ff <= pwdata[BIT_PIN];
               w_pre_ff <= pwdata[BIT_PRE_HI:BIT_PRE_LO];
               w_capm_ff <= pwdata[BIT_CAPT_MASK];
            end
            if (wr && dtc_hit(paddr, IDX_SHARED_UPPER)) begin
               in_sel_ff <= pwdata[BIT_IN_SEL];
            end
         end
      end
   end

   // Timeout flags: a terminal count in the clearing cycle keeps the flag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_tout_ff <= 1'b0;
         w_tout_ff <= 1'b0;
      end else if (stop_recovery) begin
         n_tout_ff <= 1'b0;
         w_tout_ff <= 1'b0;
      end else begin
         n_tout_ff <= n_term ||
                      (n_tout_ff && !(wr_nctl && pwdata[BIT_TIMEOUT]));
         w_tout_ff <= w_term ||
                      (w_tout_ff && !(wr_wctl && pwdata[BIT_TIMEOUT]));
      end
   end

   // In demodulation the two low bits are edge flags: set by hardware,
   // cleared by writing 1, with the set winning.
   always_comb begin
      nxt_mode = mode_ff;
      if (wr_mode) begin
         nxt_mode = dtc_mode_t'(pwdata[7:0]);
         if (mode_ff.demod) begin
            nxt_mode.init_narrow = mode_ff.init_narrow && !pwdata[1];
            nxt_mode.init_wide = mode_ff.init_wide && !pwdata[0];
         end
      end
      if (mode_ff.demod) begin
         nxt_mode.init_narrow = nxt_mode.init_narrow || edge_s.rise;
         nxt_mode.init_wide = nxt_mode.init_wide || edge_s.fall;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= dtc_mode_t'(MODE_RST);
      end else if (stop_recovery) begin
         mode_ff <= dtc_mode_t'(MODE_RST);
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_reload_ff <= RELOAD8_RST;
         w_reload_ff <= RELOAD16_RST;
      end else begin
         if (wr && dtc_hit(paddr, IDX_NARROW_RELOAD)) begin
            n_reload_ff <= pwdata[7:0];
         end
         if (wr && dtc_hit(paddr, IDX_WIDE_RELOAD_LO)) begin
            w_reload_ff[7:0] <= pwdata[7:0];
         end
         if (wr && dtc_hit(paddr, IDX_WIDE_RELOAD_HI)) begin
            w_reload_ff[15:8] <= pwdata[7:0];
         end
      end
   end

   // Prescaler for the wide timer: one tick every 1, 2, 4 or 8 clocks.
   assign pre_mask = 3'((4'h1 << w_pre_ff) - 4'h1);
   assign w_tick = (pre_cnt_ff & pre_mask) == 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_ff <= 3'h0;
      end else if (!w_en_ff || w_start) begin
         pre_cnt_ff <= 3'h1;
      end else begin
         pre_cnt_ff <= pre_cnt_ff + 3'h1;
      end
   end

   dtc_counter #(.W(8)) u_narrow (
      .pclk(pclk),
      .presetn(presetn),
      .load(n_start),
      .run(n_en_ff),
      .tick(1'b1),
      .reload(n_reload_ff),
      .count(),
      .terminal(n_term)
   );

   dtc_counter #(.W(16)) u_wide (
      .pclk(pclk),
      .presetn(presetn),
      .load(w_start || edge_ok),
      .run(w_en_ff),
      .tick(w_tick),
      .reload(w_reload_ff),
      .count(w_count),
      .terminal(w_term)
   );

   dtc_edge_filter u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin_a(capture_input_pin_a),
      .pin_b(capture_input_pin_b),
      .pin_sel(in_sel_ff),
      .glitch_sel(mode_ff.demod ? mode_ff.submode : 2'h0),
      .edge_sel(mode_ff.demod ? mode_ff.func_sel : 2'h0),
      .edge_o(edge_s)
   );

   // Capture holds the remaining count at each honoured edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_capt_ff <= 16'h0000;
      end else if (edge_ok) begin
         w_capt_ff <= w_count;
      end
   end

   // Timer outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         narrow_out_ff <= 1'b1;
      end else if (!n_en_ff) begin
         narrow_out_ff <= !mode_ff.init_narrow;
      end else if (n_start) begin
         narrow_out_ff <= mode_ff.init_narrow;
      end else if (n_term) begin
         narrow_out_ff <= !narrow_out_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wide_out_ff <= 1'b1;
      end else if (!mode_ff.demod && mode_ff.submode == SUB_FORCE0) begin
         wide_out_ff <= 1'b0;
      end else if (!mode_ff.demod && mode_ff.submode == SUB_FORCE1) begin
         wide_out_ff <= 1'b1;
      end else if (!w_en_ff) begin
         wide_out_ff <= !mode_ff.init_wide;
      end else if (w_start) begin
         wide_out_ff <= mode_ff.init_wide;
      end else if (w_term) begin
         wide_out_ff <= !wide_out_ff;
      end
   end

   always_comb begin
      case (mode_ff.func_sel)
         FN_AND: combo = narrow_out_ff && wide_out_ff;
         FN_OR: combo = narrow_out_ff || wide_out_ff;
         FN_NOR: combo = !(narrow_out_ff || wide_out_ff);
         default: combo = !(narrow_out_ff && wide_out_ff);
      endcase
   end

   // Pins and interrupt requests; all registered for clean edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_pin_out_ff <= 1'b0;
         w_pin_out_ff <= 1'b0;
         c_pin_out_ff <= 1'b0;
         w_capt_irq_ff <= 1'b0;
         w_tout_irq_ff <= 1'b0;
      end else begin
         n_pin_out_ff <= n_pin_ff ? narrow_out_ff : port_narrow_data;
         w_pin_out_ff <= w_pin_ff ? wide_out_ff : port_wide_data;
         c_pin_out_ff <= (mode_ff.combine && !mode_ff.demod) ? combo :
                         port_combined_data;
         w_capt_irq_ff <= edge_ok && w_capm_ff;
         w_tout_irq_ff <= w_term && w_toutm_ff;
      end
   end

   assign prdata = prdata_ff;
   assign pready = prdy_ff;
   assign pslverr = perr_ff;
   assign narrow_output_pin = n_pin_out_ff;
   assign wide_output_pin = w_pin_out_ff;
   assign combined_output_pin = c_pin_out_ff;
   assign wide_capture_irq = w_capt_irq_ff;
   assign wide_timeout_irq = w_tout_irq_ff;
endmodule
`default_nettype wire

// >>> dv/dtc_pins_model.sv
// Far-side model: capture input pins and normal port output data.
`timescale 1ns/1ps
`default_nettype none
module dtc_pins_model (
   input wire logic pclk,
   output logic pin_a,
   output logic pin_b,
   output logic [2:0] port_data
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b1;
      port_data = 3'h0;
   end
   // Port data counts up every cycle; bit 0 toggles each cycle, bits 1 and 2 only every 2 and 4 cycles.
   always @(posedge pclk) begin
      port_data <= port_data + 3'h1;
   end
   task automatic pulse(input int w);
      @(posedge pclk);
      pin_a <= 1'b1;
      repeat (w) @(posedge pclk);
      pin_a <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> dv/dtc_top_asserts.sv
// Port-level assertions of the dual timer block.
`timescale 1ns/1ps
`default_nettype none
module dtc_top_asserts
   import dtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic stop_recovery,
   input wire logic port_wide_data,
   input wire logic port_combined_data,
   input wire logic wide_output_pin,
   input wire logic combined_output_pin,
   input wire logic wide_capture_irq,
   input wire logic wide_timeout_irq
);
   logic wr, mapped, up, w_pin_ff, w_cm_ff, w_tm_ff, comb_ff;
   logic [1:0] up_ff;
   assign wr = psel && penable && pready && pwrite;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                 8'h18, 8'h1C, 8'h20, 8'h24};
   assign up = up_ff == 2'h3;
   // Shadow copies of the few software-owned bits the pins depend on.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {w_pin_ff, w_cm_ff, w_tm_ff, comb_ff} <= 4'h0;
         up_ff <= 2'h0;
      end else begin
         up_ff <= up ? up_ff : up_ff + 2'h1;
         if (stop_recovery) begin
            {w_pin_ff, w_tm_ff, comb_ff} <= 3'h0;
         end else if (wr && paddr == 8'h08) begin
            {w_cm_ff, w_tm_ff, w_pin_ff} <= pwdata[2:0];
         end else if (wr && paddr == 8'h04) begin
            comb_ff <= pwdata[6];
         end
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr mismatch");
   a_upper_reads_ones: assert property (pready && !pwrite &&
      paddr == 8'h0C |-> prdata[4:0] == UPPER_RSVD)
      else $error("reserved bits wrong");
   a_wide_port_pass: assert property (
      up && !w_pin_ff && !$past(w_pin_ff)
      |-> wide_output_pin == $past(port_wide_data))
      else $error("wide pin not port data");
   a_comb_port_pass: assert property (
      up && !comb_ff && !$past(comb_ff)
      |-> combined_output_pin == $past(port_combined_data))
      else $error("combined pin not port data");
   a_tout_irq_mask: assert property (
      wide_timeout_irq |-> $past(w_tm_ff))
      else $error("masked timeout request");
   a_capt_irq_mask: assert property (
      wide_capture_irq |-> $past(w_cm_ff))
      else $error("masked capture request");
endmodule
bind dtc_top dtc_top_asserts i_dtc_top_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .stop_recovery(stop_recovery),
   .port_wide_data(port_wide_data),
   .port_combined_data(port_combined_data),
   .wide_output_pin(wide_output_pin),
   .combined_output_pin(combined_output_pin),
   .wide_capture_irq(wide_capture_irq),
   .wide_timeout_irq(wide_timeout_irq)
);
`default_nettype wire

// >>> dv/tb_dual_timer_control_output.sv
// Self-checking bench of the dual timer block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
   begin \
      n_tests++; \
      if ((a) !== (b)) begin \
         fail_count++; \
         $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
      end \
   end
module tb_dual_timer_control_output;
   import dtc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, stop_recovery = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pin_a, pin_b, n_pin, w_pin, c_pin, cap, tout;
   logic [2:0] pd;
   int fail_count = 0, n_tests = 0, c;
   integer cap_cnt = 0, to_cnt = 0;
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cap_cnt <= cap_cnt + cap;
      to_cnt <= to_cnt + tout;
   end
   dtc_pins_model i_dtc_pins_model (.pclk(pclk), .pin_a(pin_a),
      .pin_b(pin_b), .port_data(pd));
   dtc_top i_dtc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_recovery(stop_recovery), .capture_input_pin_a(pin_a),
      .capture_input_pin_b(pin_b), .port_narrow_data(pd[0]),
      .port_wide_data(pd[1]), .port_combined_data(pd[2]),
      .narrow_output_pin(n_pin), .wide_output_pin(w_pin),
      .combined_output_pin(c_pin), .wide_capture_irq(cap),
      .wide_timeout_irq(tout));
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic sc_regs();
      apb(1'b0, 8'h08, 8'h00);
      `CHK(rd, 32'h00000000)
      apb(1'b1, 8'h2C, 8'hFF);
      `CHK(err, 1'b1)
      apb(1'b1, 8'h18, 8'hFF);
      apb(1'b1, 8'h1C, 8'hFF);
      apb(1'b1, 8'h08, 8'h80);
      apb(1'b0, 8'h08, 8'h00);
      `CHK(rd[7], 1'b1)
      apb(1'b1, 8'h08, 8'h20);
      apb(1'b0, 8'h08, 8'h00);
      `CHK(rd[7], 1'b0)
   endtask
   task automatic sc_count();
      apb(1'b1, 8'h18, 8'h03);
      apb(1'b1, 8'h1C, 8'h00);
      apb(1'b1, 8'h08, 8'h62);
      c = to_cnt;
      apb(1'b1, 8'h08, 8'hC2);
      repeat (20) @(posedge pclk);
      `CHK(to_cnt - c, 1)
      apb(1'b0, 8'h08, 8'h00);
      `CHK(rd[7:0], 8'h62)
      apb(1'b1, 8'h08, 8'h42);
      apb(1'b0, 8'h08, 8'h00);
      `CHK(rd[7:0], 8'h62)
      apb(1'b1, 8'h08, 8'h62);
      apb(1'b0, 8'h08, 8'h00);
      `CHK(rd[7:0], 8'h42)
      c = to_cnt;
      apb(1'b1, 8'h08, 8'h82);
      repeat (24) @(posedge pclk);
      `CHK(to_cnt - c >= 5, 1'b1)
      apb(1'b1, 8'h08, 8'h80);
      c = to_cnt;
      repeat (20) @(posedge pclk);
      `CHK(to_cnt - c, 0)
      // Divide by eight: one timeout per 32 clocks instead of per 4.
      apb(1'b1, 8'h08, 8'h9E);
      c = to_cnt;
      repeat (64) @(posedge pclk);
      `CHK(to_cnt - c inside {[1:2]}, 1'b1)
      stop_recovery <= 1'b1;
      @(posedge pclk);
      stop_recovery <= 1'b0;
      @(posedge pclk);
      apb(1'b0, 8'h08, 8'h00);
      `CHK(rd[7:0], 8'h1C)
   endtask
   task automatic sc_pins();
      logic n, w, e;
      apb(1'b1, 8'h00, 8'h01);
      apb(1'b1, 8'h08, 8'h01);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, 8'h04, {2'b01, i[1:0], 2'b00, i[3:2]});
         repeat (4) @(posedge pclk);
         n = ~i[3];
         w = ~i[2];
         e = i[1] ? ~(i[0] ? n & w : n | w) : (i[0] ? n | w : n & w);
         `CHK(n_pin, n)
         `CHK(w_pin, w)
         `CHK(c_pin, e)
      end
      apb(1'b1, 8'h04, 8'h08);
      repeat (4) @(posedge pclk);
      `CHK(w_pin, 1'b0)
      apb(1'b1, 8'h04, 8'h0D);
      repeat (4) @(posedge pclk);
      `CHK(w_pin, 1'b1)
      apb(1'b1, 8'h08, 8'h03);
      apb(1'b1, 8'h04, 8'h04);
      c = to_cnt;
      apb(1'b1, 8'h00, 8'h81);
      repeat (24) @(posedge pclk);
      `CHK(to_cnt - c >= 2, 1'b1)
      apb(1'b1, 8'h04, 8'h00);
      apb(1'b1, 8'h08, 8'h00);
      apb(1'b1, 8'h00, 8'h00);
      repeat (8) @(posedge pclk);
   endtask
   task automatic sc_edge();
      apb(1'b1, 8'h08, 8'h00);
      apb(1'b1, 8'h04, 8'h9C);
      apb(1'b1, 8'h18, 8'hFF);
      apb(1'b1, 8'h1C, 8'hFF);
      apb(1'b1, 8'h08, 8'h84);
      c = cap_cnt;
      i_dtc_pins_model.pulse(4);
      repeat (20) @(posedge pclk);
      `CHK(cap_cnt - c, 0)
      i_dtc_pins_model.pulse(20);
      repeat (20) @(posedge pclk);
      `CHK(cap_cnt - c, 1)
      apb(1'b0, 8'h04, 8'h00);
      `CHK(rd[1:0], 2'b10)
      apb(1'b1, 8'h08, 8'hC4);
      c = cap_cnt;
      i_dtc_pins_model.pulse(20);
      repeat (20) @(posedge pclk);
      `CHK(cap_cnt - c, 0)
      apb(1'b1, 8'h08, 8'h00);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      sc_regs();
      sc_count();
      sc_pins();
      sc_edge();
      print_verdict();
   end
   initial begin
      #1000000;
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire

// >>> inc/dtc_pkg.sv
// Shared constants, field layouts and carrier types of the dual timer block.
package dtc_pkg;

   // Register indices; the APB byte address is four times the index.
   localparam logic [7:0] IDX_NARROW_CTL = 8'h00;
   localparam logic [7:0] IDX_SHARED_MODE = 8'h01;
   localparam logic [7:0] IDX_WIDE_CTL = 8'h02;
   localparam logic [7:0] IDX_SHARED_UPPER = 8'h03;
   localparam logic [7:0] IDX_NARROW_RELOAD = 8'h04;
   localparam logic [7:0] IDX_WIDE_RELOAD_LO = 8'h06;
   localparam logic [7:0] IDX_WIDE_RELOAD_HI = 8'h07;
   localparam logic [7:0] IDX_WIDE_CAPT_LO = 8'h08;
   localparam logic [7:0] IDX_WIDE_CAPT_HI = 8'h09;

   // Field positions of the two timer control registers and the shared upper register.
   localparam int BIT_EN = 7;
   localparam int BIT_SINGLE = 6;
   localparam int BIT_TIMEOUT = 5;
   localparam int BIT_PRE_HI = 4;
   localparam int BIT_PRE_LO = 3;
   localparam int BIT_CAPT_MASK = 2;
   localparam int BIT_TOUT_MASK = 1;
   localparam int BIT_PIN = 0;
   localparam int BIT_IN_SEL = 7;

   // Reset values.
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] RELOAD8_RST = 8'h00;
   localparam logic [15:0] RELOAD16_RST = 16'h0000;
   localparam logic [1:0] PRE_RST = 2'h0;
   localparam logic [4:0] UPPER_RSVD = 5'h1F;

   // Transmit submode codes.
   localparam logic [1:0] SUB_NORMAL = 2'h0;
   localparam logic [1:0] SUB_PINGPONG = 2'h1;
   localparam logic [1:0] SUB_FORCE0 = 2'h2;
   localparam logic [1:0] SUB_FORCE1 = 2'h3;

   // Output combination codes.
   localparam logic [1:0] FN_AND = 2'h0;
   localparam logic [1:0] FN_OR = 2'h1;
   localparam logic [1:0] FN_NOR = 2'h2;
   localparam logic [1:0] FN_NAND = 2'h3;

   // Glitch widths in system clock cycles for codes 00 to 11.
   localparam logic [3:0] GLITCH_0 = 4'h1;
   localparam logic [3:0] GLITCH_1 = 4'h2;
   localparam logic [3:0] GLITCH_2 = 4'h4;
   localparam logic [3:0] GLITCH_3 = 4'h8;

   typedef struct packed {
      logic demod;
      logic combine;
      logic [1:0] func_sel;
      logic [1:0] submode;
      logic init_narrow;
      logic init_wide;
   } dtc_mode_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } dtc_edge_t;

   function automatic logic dtc_hit(input logic [7:0] addr,
                                    input logic [7:0] idx);
      return addr == {idx[5:0], 2'b00};
   endfunction

   function automatic logic [3:0] dtc_glitch_len(input logic [1:0] sel);
      case (sel)
         2'h0: return GLITCH_0;
         2'h1: return GLITCH_1;
         2'h2: return GLITCH_2;
         default: return GLITCH_3;
      endcase
   endfunction

endpackage
